//--- rtl/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// core clock and pin timing
`define CORE_CLK_PERIOD_NS 10
`define XTRIG_MIN_LOW_NS   800
`define XTRIG_MIN_LOW_CYC  ((`XTRIG_MIN_LOW_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

// serial frame edge counts
`define CMD_BITS_EDGE      5'h04
`define SHORT_SAMPLE_EDGE  5'h10
`define LONG_SAMPLE_EDGE   5'h1c
`define EDGE_CNT_MAX       5'h1f

// command codes
`define CMD_READ_FIFO      4'he

// result path
`define RESULT_BITS        10
`define RESULT_FIFO_DEPTH  8
`define SEQ_LEN            8

// threshold levels per trigger-level code
`define TRIG_LVL_CODE0     4'h7
`define TRIG_LVL_CODE1     4'h5
`define TRIG_LVL_CODE2     4'h3
`define TRIG_LVL_CODE3     4'h1

`endif

//--- rtl/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [1:0] {
    MODE_ONE_SHOT     = 2'h0,
    MODE_REPEAT       = 2'h1,
    MODE_SWEEP        = 2'h2,
    MODE_REPEAT_SWEEP = 2'h3
  } conv_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_CONV = 2'h2
  } seq_state_e;

  typedef struct packed {
    conv_mode_e mode;
    logic [1:0] seq_sel;
    logic       pin_is_eoc;
    logic       long_sample;
    logic [1:0] trig_level;
  } conv_cfg_s;

  typedef struct packed {
    logic [2:0] chan;
    logic [9:0] data;
  } result_s;

  typedef logic [3:0] cmd_t;

endpackage

//--- rtl/result_fifo.sv
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // control
  input  wire logic                         clear,
  // fill side
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [WIDTH-1:0]             in_data,
  // drain side
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  out_data,
  output logic [$clog2(DEPTH+1)-1:0]        level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("result_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [LW-1:0]    level_r;
  logic             push;
  logic             pop;

  assign in_ready  = !clear && (level_r != LW'(DEPTH));
  assign out_valid = !clear && (level_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign level     = level_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk) begin
      if (ce && push && wr_ptr_r == AW'(i)) begin
        mem_r[i] <= in_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else if (ce) begin
      if (clear) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        level_r  <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= wr_ptr_r + AW'(1);
        end
        if (pop) begin
          rd_ptr_r <= rd_ptr_r + AW'(1);
        end
        level_r <= level_r + LW'(push) - LW'(pop);
      end
    end
  end

endmodule

//--- rtl/adc_conversion_mode_sequencer.sv
// Operation
// - one-shot results skip the FIFO and go straight to the output.
// - one-shot raises EOC while converting, or INT once conversion is done.
// - each select-frame trigger that is not blocked runs one conversion of one channel.
// - repeat mode fills the FIFO from one channel up to the threshold.
// - repeat mode flushes and restarts fill if not read after threshold.
// - sweep converts the chosen sequence in order, storing each result.
// - sweep stops when threshold is reached before the list ends.
// - sweep modes raise the interrupt when FIFO level hits the threshold.
// - next sweep waits until a FIFO read has emptied the FIFO.
// - repeat sweep keeps sweeping after the threshold interrupt.
// - repeat sweep keeps stored results when next frame reads the FIFO.
// - repeat sweep flushes FIFO on a non-read frame or conversion pin.
// - trigger-level code picks threshold 7, 5, 3 or 1.
// - sequence-select code picks one of four fixed channel orders.
// - pin-function bit picks interrupt (0) or end-of-conversion (1).
// - frame trigger starts conversion at sclk edge 16 or 28.
`timescale 1ns/1ns
`include "adc_seq_map.svh"
module adc_conversion_mode_sequencer
  import adc_seq_pkg::*;
#(
  parameter int FIFO_DEPTH = `RESULT_FIFO_DEPTH
) (
  // core clock domain
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  // serial link
  input  wire logic                           sclk,
  input  wire logic                           cs_n,
  input  wire logic                           frame_sync_strobe,
  input  wire logic                           sdi,
  input  wire logic                           external_sample_trigger,
  // configuration
  input  wire conv_cfg_s                      conversion_config_word,
  // converter core
  output logic                                conv_start,
  output logic [2:0]                          conv_chan,
  input  wire logic                           conv_done,
  input  wire logic [`RESULT_BITS-1:0]        conv_result,
  // result stream
  output logic                                result_valid,
  output result_s                             result_data,
  input  wire logic                           result_ready,
  // status
  output logic                                status_n,
  output logic [$clog2(FIFO_DEPTH+1)-1:0]     fifo_level
);
  localparam int          LW          = $clog2(FIFO_DEPTH+1);
  localparam logic [7:0]  XT_LOW_CYC  = 8'(`XTRIG_MIN_LOW_CYC);

  if (FIFO_DEPTH < `RESULT_FIFO_DEPTH) begin : g_bad_depth
    $error("fifo must hold at least the largest threshold");
  end

  function automatic logic fifo_mode(input conv_mode_e m);
    return m != MODE_ONE_SHOT;
  endfunction

  function automatic logic sweep_mode(input conv_mode_e m);
    return m == MODE_SWEEP || m == MODE_REPEAT_SWEEP;
  endfunction

  function automatic logic [3:0] thr_of(input logic [1:0] code);
    case (code)
      2'h0:    return `TRIG_LVL_CODE0;
      2'h1:    return `TRIG_LVL_CODE1;
      2'h2:    return `TRIG_LVL_CODE2;
      default: return `TRIG_LVL_CODE3;
    endcase
  endfunction

  function automatic logic [2:0] seq_chan(input logic [1:0] sel, input logic [2:0] idx);
    case (sel)
      2'h0:    return idx;
      2'h1:    return {idx[1:0], 1'b0};
      2'h2:    return {idx[2:1], 1'b0};
      default: return {1'b0, idx[0], 1'b0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: frame edge count and command capture

  logic       ce_l_meta;
  logic       ce_l;
  logic       ls_meta;
  logic       ls_sync;
  logic [4:0] edge_cnt_r;
  logic [4:0] edge_cnt_nxt;
  logic [4:0] fire_edge;
  cmd_t       cmd_sh_r;
  cmd_t       cmd_hold_r;
  logic       tog_r;
  logic       fire;

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_l_meta <= 1'b0;
      ce_l      <= 1'b0;
      ls_meta   <= 1'b0;
      ls_sync   <= 1'b0;
    end else begin
      ce_l_meta <= ce;
      ce_l      <= ce_l_meta;
      ls_meta   <= conversion_config_word.long_sample;
      ls_sync   <= ls_meta;
    end
  end

  assign edge_cnt_nxt = edge_cnt_r + 5'h01;
  assign fire_edge    = ls_sync ? `LONG_SAMPLE_EDGE : `SHORT_SAMPLE_EDGE;
  assign fire         = ce_l && !frame_sync_strobe && (edge_cnt_nxt == fire_edge);

  // chip select high ends the frame without needing an sclk edge
  always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
    if (!rst_n) begin
      edge_cnt_r <= '0;
      cmd_sh_r   <= '0;
    end else if (cs_n) begin
      edge_cnt_r <= '0;
      cmd_sh_r   <= '0;
    end else if (ce_l) begin
      if (frame_sync_strobe) begin
        edge_cnt_r <= '0;
        cmd_sh_r   <= '0;
      end else begin
        if (edge_cnt_r != `EDGE_CNT_MAX) begin
          edge_cnt_r <= edge_cnt_nxt;
        end
        if (edge_cnt_r < `CMD_BITS_EDGE) begin
          cmd_sh_r <= {cmd_sh_r[2:0], sdi};
        end
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_hold_r <= '0;
      tog_r      <= 1'b0;
    end else if (fire) begin
      cmd_hold_r <= cmd_sh_r;
      tog_r      <= ~tog_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core domain: crossings and pin conditioning

  logic       tog_meta;
  logic       tog_sync;
  logic       tog_seen;
  logic       csn_meta;
  logic       csn_sync;
  logic       xt_meta;
  logic       xt_sync;
  logic       xt_prev;
  logic [7:0] xt_low_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
      csn_meta <= 1'b1;
      csn_sync <= 1'b1;
      xt_meta  <= 1'b1;
      xt_sync  <= 1'b1;
      xt_prev  <= 1'b1;
    end else if (ce) begin
      tog_meta <= tog_r;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      csn_meta <= cs_n;
      csn_sync <= csn_meta;
      xt_meta  <= external_sample_trigger;
      xt_sync  <= xt_meta;
      xt_prev  <= xt_sync;
    end
  end

  // low time of the conversion pin, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xt_low_r <= '0;
    end else if (ce) begin
      if (xt_sync) begin
        xt_low_r <= '0;
      end else if (xt_low_r != XT_LOW_CYC) begin
        xt_low_r <= xt_low_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  conv_mode_e mode;
  seq_state_e state_r;
  logic [2:0] sel_chan_r;
  logic [2:0] seq_idx_r;
  logic       thr_hit_r;
  logic       hold_r;
  logic       drain_r;
  logic       sweep_done_r;
  logic       int_r;
  logic       int_nxt;
  logic       frame_evt;
  logic       is_read;
  logic       is_sel;
  logic       xt_rise;
  logic       conv_req;
  logic       svc;
  logic       flush;
  logic       retain;
  logic       blocked;
  logic       start;
  logic       direct;
  logic       push;
  logic       thr_evt;
  logic       list_end;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic       fifo_empty;
  result_s    fifo_out;
  logic [LW-1:0] level;
  logic [2:0] chan_pick;

  assign mode      = conversion_config_word.mode;
  assign frame_evt = tog_sync ^ tog_seen;
  assign is_read   = cmd_hold_r == `CMD_READ_FIFO;
  assign is_sel    = !cmd_hold_r[3];
  // conversion pin ignored while chip select is active
  assign xt_rise   = xt_sync && !xt_prev && csn_sync && (xt_low_r == XT_LOW_CYC);
  assign conv_req  = (frame_evt && is_sel) || xt_rise;
  assign svc       = frame_evt || xt_rise;
  assign fifo_empty = level == '0;

  assign flush  = thr_hit_r && svc && !(frame_evt && is_read) &&
                  (mode == MODE_REPEAT || mode == MODE_REPEAT_SWEEP);
  assign retain = thr_hit_r && frame_evt && is_read;

  // no new sweep before FIFO emptied
  assign blocked = (mode == MODE_SWEEP && sweep_done_r) ||
                   (hold_r && !fifo_empty) ||
                   (fifo_mode(mode) && !fifo_in_ready && !flush) ||
                   (!fifo_mode(mode) && result_valid && !result_ready);
  assign start   = conv_req && (state_r == ST_IDLE) && !blocked;

  // fixed visiting orders in sweep modes
  // repeat channel set by select frame
  assign chan_pick = sweep_mode(mode) ? seq_chan(conversion_config_word.seq_sel, seq_idx_r) :
                     (frame_evt && is_sel) ? cmd_hold_r[2:0] : sel_chan_r;

  assign direct  = conv_done && (state_r == ST_CONV) && !fifo_mode(mode);
  assign push    = conv_done && (state_r == ST_CONV) && fifo_mode(mode);
  assign thr_evt = push && ((LW'(level) + LW'(1)) == LW'(thr_of(conversion_config_word.trig_level)));
  assign list_end = push && (seq_idx_r == 3'h0);

  assign fifo_out_ready = drain_r && !direct && (!result_valid || result_ready);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      conv_start <= 1'b0;
      conv_chan  <= '0;
      sel_chan_r <= '0;
    end else if (ce) begin
      conv_start <= start;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r   <= ST_CONV;
            conv_chan <= chan_pick;
            if (!sweep_mode(mode)) begin
              sel_chan_r <= chan_pick;
            end
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // sweep stops at threshold or list end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_idx_r    <= '0;
      sweep_done_r <= 1'b0;
    end else if (ce) begin
      if (start && sweep_mode(mode)) begin
        seq_idx_r <= seq_idx_r + 3'h1;
      end
      if (mode == MODE_SWEEP && (thr_evt || list_end)) begin
        sweep_done_r <= 1'b1;
      end else if (sweep_done_r && fifo_empty && state_r == ST_IDLE) begin
        sweep_done_r <= 1'b0;
        seq_idx_r    <= '0;
      end
    end
  end

  // threshold window, retention and drain flags; set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_hit_r <= 1'b0;
      hold_r    <= 1'b0;
      drain_r   <= 1'b0;
    end else if (ce) begin
      thr_hit_r <= thr_evt || (thr_hit_r && !svc);
      hold_r    <= retain || (hold_r && !fifo_empty);
      drain_r   <= (frame_evt && is_read) || (drain_r && !fifo_empty);
    end
  end

  assign int_nxt = direct || thr_evt || (int_r && !svc);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_r    <= 1'b0;
      status_n <= 1'b1;
    end else if (ce) begin
      int_r <= int_nxt;
      if (conversion_config_word.pin_is_eoc) begin
        status_n <= !((state_r == ST_IDLE && start) || (state_r == ST_CONV && !conv_done));
      end else begin
        status_n <= !int_nxt;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result_data  <= '0;
    end else if (ce) begin
      if (direct) begin
        result_valid <= 1'b1;
        result_data  <= '{chan: conv_chan, data: conv_result};
      end else if (fifo_out_ready && fifo_out_valid) begin
        result_valid <= 1'b1;
        result_data  <= fifo_out;
      end else if (result_ready) begin
        result_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_level <= '0;
    end else if (ce) begin
      fifo_level <= level;
    end
  end

  result_fifo #(
    .WIDTH ($bits(result_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .clear     (flush),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({conv_chan, conv_result}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out),
    .level     (level)
  );

endmodule

//--- verification/adc_seq_asserts.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"
module adc_seq_asserts
  import adc_seq_pkg::*;
#(
  parameter int FIFO_DEPTH = `RESULT_FIFO_DEPTH
) (
  // clock and reset
  input wire logic                             core_clk,
  input wire logic                             rst_n,
  // converter side
  input wire conv_cfg_s                        conversion_config_word,
  input wire logic                             conv_start,
  input wire logic [2:0]                       conv_chan,
  input wire logic                             conv_done,
  input wire logic [`RESULT_BITS-1:0]          conv_result,
  // result side
  input wire logic                             result_valid,
  input wire result_s                          result_data,
  input wire logic                             result_ready,
  input wire logic                             status_n,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0]  fifo_level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  conv_cfg_s  cfg;
  logic [3:0] thr;
  logic       one;
  assign cfg = conversion_config_word;
  assign thr = 4'h7 - {1'b0, cfg.trig_level, 1'b0};
  assign one = (cfg.mode == MODE_ONE_SHOT);
  ////////////////////////////////////////////////////////////
  sequence s_result_out;
    ##1 result_valid && result_data.data == $past(conv_result);
  endsequence
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  property p_chan_hold; !conv_start |-> $stable(conv_chan); endproperty
  property p_eoc_busy; one && cfg.pin_is_eoc && conv_start |-> ##[0:1] !status_n; endproperty
  property p_int_after; one && !cfg.pin_is_eoc && conv_done |-> ##[1:2] !status_n; endproperty
  property p_int_quiet; one && !cfg.pin_is_eoc && conv_start |=> status_n [*3]; endproperty
  property p_bypass; one && conv_done && !result_valid |-> s_result_out; endproperty
  property p_no_fifo; one && fifo_level == 0 |=> fifo_level == 0; endproperty
  property p_valid_hold;
    result_valid && !result_ready |=> result_valid && $stable(result_data);
  endproperty
  property p_thr_int;
    !one && !cfg.pin_is_eoc && $changed(fifo_level) && fifo_level == thr |-> ##[0:2] !status_n;
  endproperty
  property p_level_cap; !one |-> fifo_level <= thr; endproperty
  ////////////////////////////////////////////////////////////
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel moved without start");
  a_eoc_busy: assert property (p_eoc_busy)
    else $error("no eoc while converting");
  a_int_after: assert property (p_int_after)
    else $error("no interrupt after conversion");
  a_int_quiet: assert property (p_int_quiet)
    else $error("interrupt during conversion");
  a_bypass: assert property (p_bypass)
    else $error("one shot result not direct");
  a_no_fifo: assert property (p_no_fifo)
    else $error("fifo used in one shot");
  a_valid_hold: assert property (p_valid_hold)
    else $error("result dropped before accept");
  a_thr_int: assert property (p_thr_int)
    else $error("no interrupt at threshold");
  a_level_cap: assert property (p_level_cap)
    else $error("fifo filled past threshold");
endmodule
bind adc_conversion_mode_sequencer adc_seq_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .core_clk, .rst_n, .conversion_config_word, .conv_start, .conv_chan, .conv_done,
  .conv_result, .result_valid, .result_data, .result_ready, .status_n, .fifo_level);

//--- verification/host_port.sv
`timescale 1ns/1ns
module host_port
  import adc_seq_pkg::*;
(
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic frame_sync_strobe,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    frame_sync_strobe = 1'b0;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // link clock edges, 6 ns period
  task automatic idle(input int n);
    repeat (n) begin
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
  endtask
  task automatic send(input cmd_t cmd, input int edges, input logic lead);
    cs_n = 1'b0;
    if (lead) begin
      frame_sync_strobe = 1'b1;
      idle(1);
      frame_sync_strobe = 1'b0;
    end
    for (int e = 1; e <= edges; e++) begin
      sdi = (e <= 4) ? cmd[4-e] : ~sdi;
      idle(1);
    end
    #3 cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb
  import adc_seq_pkg::*;
();
  typedef struct {
    conv_mode_e mode;
    logic [1:0] sel;
    logic [1:0] trig;
    cmd_t       cmd;
    logic       lead;
    logic [3:0] lvl;
  } row_s;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       sclk, cs_n, frame_sync_strobe, sdi, conv_start, result_valid, status_n, ok;
  logic       external_sample_trigger = 1'b1;
  logic       conv_done = 1'b0;
  logic       result_ready = 1'b0;
  logic       busy_n = 1'b1;
  conv_cfg_s  cfg = '0;
  logic [2:0] conv_chan;
  logic [2:0] ch = '0;
  logic [9:0] conv_result;
  result_s    result_data;
  logic [3:0] fifo_level;
  logic [2:0] exp_ch [8];
  int         failures = 0;
  int         check_count = 0;
  int         busy_cnt = 0;
  row_s       rows [5] = '{
    '{MODE_SWEEP, 2'h0, 2'h0, 4'h3, 1'b0, 4'h7},
    '{MODE_SWEEP, 2'h1, 2'h1, 4'h1, 1'b0, 4'h5},
    '{MODE_SWEEP, 2'h2, 2'h2, 4'h0, 1'b1, 4'h3},
    '{MODE_REPEAT_SWEEP, 2'h3, 2'h3, 4'h2, 1'b0, 4'h1},
    '{MODE_REPEAT, 2'h0, 2'h2, 4'h5, 1'b1, 4'h3}};

  always #5 core_clk = ~core_clk;

  adc_conversion_mode_sequencer dut (
    .core_clk, .rst_n, .ce, .sclk, .cs_n, .frame_sync_strobe, .sdi,
    .external_sample_trigger, .conversion_config_word(cfg), .conv_start, .conv_chan,
    .conv_done, .conv_result, .result_valid, .result_data, .result_ready,
    .status_n, .fifo_level);
  host_port host (.sclk, .cs_n, .frame_sync_strobe, .sdi);

  // converter core: result five cycles after start
  assign conv_result = {7'h40, conv_chan};
  always @(posedge core_clk) begin
    #1;
    conv_done = (busy_cnt == 1);
    if (conv_start === 1'b1) busy_cnt = 5;
    else if (busy_cnt != 0) busy_cnt--;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [2:0] seq_ch(input logic [1:0] sel, input int i);
    case (sel)
      2'h0: return 3'(i);
      2'h1: return 3'((i * 2) % 8);
      2'h2: return 3'((i / 2) * 2);
      default: return 3'((i % 2) * 2);
    endcase
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset(input conv_cfg_s c);
    rst_n = 1'b0;
    cfg = c;
    result_ready = 1'b0;
    host.idle(2);
    step(4);
    `CHECK({conv_start, result_valid, status_n, fifo_level}, 7'h10)
    rst_n = 1'b1;
    host.idle(3);
    step(2);
  endtask
  task automatic hit(input cmd_t cmd, input int edges, input logic lead, input logic pin);
    ok = 1'b0;
    if (pin) begin
      external_sample_trigger = 1'b0;
      step(85);
      external_sample_trigger = 1'b1;
    end else begin
      host.send(cmd, edges, lead);
      step(1);
    end
    repeat (12) begin
      step(1);
      if (conv_start === 1'b1) begin
        ok = 1'b1;
        ch = conv_chan;
        step(1);
        busy_n = status_n;
      end
    end
    step(8);
  endtask
  task automatic drain(input int n);
    int i;
    i = 0;
    host.send(`CMD_READ_FIFO, 16, 1'b0);
    repeat (40) begin
      step(1);
      result_ready = ~result_ready;
      if (result_ready && result_valid === 1'b1) begin
        if (i < n) `CHECK(result_data, {exp_ch[i], 7'h40, exp_ch[i]})
        i++;
      end
    end
    `CHECK(i, n)
    `CHECK(fifo_level, 4'h0)
  endtask
  task automatic accept();
    result_ready = 1'b1;
    step(1);
    result_ready = 1'b0;
    `CHECK(result_valid, 1'b0)
  endtask
  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
  initial begin
    foreach (rows[r]) begin
      do_reset({rows[r].mode, rows[r].sel, 2'b00, rows[r].trig});
      for (int k = 0; k < rows[r].lvl; k++) begin
        exp_ch[k] = (rows[r].mode == MODE_REPEAT) ? rows[r].cmd[2:0] : seq_ch(rows[r].sel, k);
        hit(rows[r].cmd, 16, rows[r].lead, 1'b0);
        `CHECK({ok, ch}, {1'b1, exp_ch[k]})
      end
      `CHECK(fifo_level, rows[r].lvl)
      `CHECK(status_n, 1'b0)
      drain(rows[r].lvl);
      `CHECK(status_n, 1'b1)
      done_test("row");
    end
    do_reset({MODE_ONE_SHOT, 2'h0, 1'b1, 1'b0, 2'h0});
    hit(4'h3, 16, 1'b0, 1'b0);
    `CHECK(busy_n, 1'b0)
    `CHECK(result_data, {3'h3, 7'h40, 3'h3})
    `CHECK(fifo_level, 4'h0)
    accept();
    done_test("one_shot_eoc");
    do_reset({MODE_ONE_SHOT, 2'h0, 1'b0, 1'b0, 2'h0});
    hit(4'h6, 16, 1'b1, 1'b0);
    `CHECK(busy_n, 1'b1)
    `CHECK(status_n, 1'b0)
    accept();
    hit(4'h1, 16, 1'b0, 1'b0);
    `CHECK({busy_n, ch}, 4'h9)
    `CHECK(status_n, 1'b0)
    `CHECK(result_data, {3'h1, 7'h40, 3'h1})
    accept();
    hit(4'h2, 15, 1'b0, 1'b0);
    `CHECK(ok, 1'b0)
    done_test("one_shot_int");
    do_reset({MODE_ONE_SHOT, 2'h0, 1'b0, 1'b1, 2'h0});
    hit(4'h2, 16, 1'b0, 1'b0);
    `CHECK(ok, 1'b0)
    hit(4'h2, 28, 1'b0, 1'b0);
    `CHECK({ok, ch}, 4'ha)
    accept();
    hit(4'h0, 0, 1'b0, 1'b1);
    `CHECK({ok, ch}, 4'ha)
    done_test("sampling");
    do_reset({MODE_SWEEP, 2'h0, 1'b0, 1'b0, 2'h3});
    hit(4'h0, 16, 1'b0, 1'b0);
    hit(4'h0, 16, 1'b0, 1'b0);
    `CHECK(ok, 1'b0)
    `CHECK(fifo_level, 4'h1)
    exp_ch[0] = 3'h0;
    drain(1);
    hit(4'h0, 16, 1'b0, 1'b0);
    `CHECK({ok, ch}, 4'h8)
    done_test("sweep_hold");
    do_reset({MODE_REPEAT, 2'h0, 1'b0, 1'b0, 2'h2});
    repeat (4) hit(4'h4, 16, 1'b0, 1'b0);
    `CHECK(fifo_level, 4'h1)
    done_test("repeat_flush");
    do_reset({MODE_REPEAT_SWEEP, 2'h0, 1'b0, 1'b0, 2'h3});
    hit(4'h0, 16, 1'b0, 1'b0);
    hit(4'h0, 0, 1'b0, 1'b1);
    `CHECK({ok, ch}, 4'h9)
    `CHECK(fifo_level, 4'h1)
    exp_ch[0] = 3'h1;
    drain(1);
    done_test("repeat_sweep_pin");
    ce = 1'b0;
    hit(4'h0, 16, 1'b0, 1'b0);
    `CHECK({ok, fifo_level}, 5'h00)
    ce = 1'b1;
    host.idle(3);
    done_test("freeze");
    give_verdict();
  end
endmodule
